// File: core/mas_pkg.sv
package mas_pkg;
  // operation select codes
  typedef enum logic [3:0] {
    MAS_OP_NONE,
    MAS_OP_PTR_ADD,
    MAS_OP_AND_IMM,
    MAS_OP_ADD_IMM,
    MAS_OP_AND_REG,
    MAS_OP_ADD_REG,
    MAS_OP_ADC_REG,
    MAS_OP_ASR_REG,
    MAS_OP_BCLR_REG
  } mas_op_t;

  // widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned PIMM_W = 6;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BIDX_W = 3;
  localparam int unsigned NIB_MSB = 3;

  // destination bit encodings
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // one instruction request from the decoder
  typedef struct packed {
    mas_op_t op;
    logic dest;
    logic [7:0] imm;
    logic [6:0] faddr;
    logic [2:0] bidx;
    logic ptr_sel;
    logic [5:0] pimm;
  } mas_req_t;

  // status flags
  typedef struct packed {
    logic carry;
    logic low_nibble_flag;
    logic zero;
  } mas_flags_t;

  // file register write-back
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } mas_fwr_t;
endpackage

// File: core/mas_adder.sv
// 8-bit adder with nibble and byte carry outs
module mas_adder (
  // operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  // results
  output logic [7:0] sum_o,
  output logic c3_o,
  output logic c7_o
);
  logic [4:0] lo; // low nibble sum with carry
  logic [4:0] hi; // high nibble sum with carry

  // two nibble stages so the digit carry falls out directly
  always_comb begin
    lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    hi = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo[4]};
    sum_o = {hi[3:0], lo[3:0]};
    c3_o = lo[4];
    c7_o = hi[4];
  end
endmodule

// File: core/mas_alu.sv
module mas_alu (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // instruction request
  input wire logic req_valid_i,
  input wire mas_pkg::mas_req_t req_i,
  // file register read data for faddr
  input wire logic [7:0] freg_rdata_i,
  // state
  output logic [7:0] acc_o,
  output mas_pkg::mas_flags_t flags_o,
  output logic [15:0] pointer_pair0_o,
  output logic [15:0] pointer_pair1_o,
  output mas_pkg::mas_fwr_t fwr_o
);
  logic [7:0] acc_r; // accumulator
  mas_pkg::mas_flags_t flags_r; // status flags
  logic [15:0] ptr_r [2]; // pointer pairs
  mas_pkg::mas_fwr_t fwr_r; // write-back strobe
  logic [7:0] add_b; // second adder operand
  logic add_cin; // adder carry in
  logic [7:0] add_sum; // adder sum
  logic add_c3; // carry out of bit 3
  logic add_c7; // carry out of bit 7
  logic [7:0] res; // result byte
  logic wr_acc; // result to accumulator
  logic wr_reg; // result to file register
  logic upd_z; // update zero
  logic upd_c; // update carry
  logic upd_dc; // update digit carry
  logic new_c; // new carry value
  logic [15:0] ptr_ext; // sign-extended pointer offset
  logic is_ptr; // pointer add active

  // the immediate add uses the literal, others the file register
  always_comb begin
    add_b = freg_rdata_i;
    add_cin = 1'b0;
    if (req_i.op == mas_pkg::MAS_OP_ADD_IMM) begin
      add_b = req_i.imm;
    end else if (req_i.op == mas_pkg::MAS_OP_ADC_REG) begin
      add_cin = flags_r.carry;
    end
  end

  // shared adder
  mas_adder u_add (
    .a_i(acc_r),
    .b_i(add_b),
    .cin_i(add_cin),
    .sum_o(add_sum),
    .c3_o(add_c3),
    .c7_o(add_c7)
  );

  // result and flag selection
  always_comb begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_reg = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    new_c = add_c7;
    is_ptr = 1'b0;
    if (req_valid_i) begin
      case (req_i.op)
        mas_pkg::MAS_OP_PTR_ADD: begin
          is_ptr = 1'b1;
        end
        mas_pkg::MAS_OP_AND_IMM: begin
          res = acc_r & req_i.imm;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        mas_pkg::MAS_OP_ADD_IMM: begin
          res = add_sum;
          wr_acc = 1'b1;
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end
        mas_pkg::MAS_OP_AND_REG: begin
          res = acc_r & freg_rdata_i;
          upd_z = 1'b1;
          wr_acc = (req_i.dest == mas_pkg::DEST_ACC);
          wr_reg = (req_i.dest == mas_pkg::DEST_REG);
        end
        mas_pkg::MAS_OP_ADD_REG,
        mas_pkg::MAS_OP_ADC_REG: begin
          res = add_sum;
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
          wr_acc = (req_i.dest == mas_pkg::DEST_ACC);
          wr_reg = (req_i.dest == mas_pkg::DEST_REG);
        end
        mas_pkg::MAS_OP_ASR_REG: begin
          res = {freg_rdata_i[7], freg_rdata_i[7:1]};
          new_c = freg_rdata_i[0];
          upd_z = 1'b1;
          upd_c = 1'b1;
          wr_acc = (req_i.dest == mas_pkg::DEST_ACC);
          wr_reg = (req_i.dest == mas_pkg::DEST_REG);
        end
        mas_pkg::MAS_OP_BCLR_REG: begin
          res = freg_rdata_i & ~(8'h01 << req_i.bidx);
          wr_reg = 1'b1;
        end
        default: begin
          res = 8'h00;
        end
      endcase
    end
  end

  // sign extension of the pointer offset
  always_comb begin
    ptr_ext = {{(mas_pkg::PTR_W - mas_pkg::PIMM_W){
      req_i.pimm[mas_pkg::PIMM_W - 1]}}, req_i.pimm};
  end

  // accumulator update
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_r <= mas_pkg::ACC_RST;
    end else if (wr_acc) begin
      acc_r <= res;
    end
  end

  // status flags update
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flags_r <= '0;
    end else begin
      if (upd_z) begin
        flags_r.zero <= (res == 8'h00);
      end
      if (upd_c) begin
        flags_r.carry <= new_c;
      end
      if (upd_dc) begin
        flags_r.low_nibble_flag <= add_c3;
      end
    end
  end

  // pointer pairs, 16-bit sum drops the carry so it wraps
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ptr_r[0] <= mas_pkg::PTR_RST;
      ptr_r[1] <= mas_pkg::PTR_RST;
    end else if (is_ptr) begin
      ptr_r[req_i.ptr_sel] <= 16'(ptr_r[req_i.ptr_sel] + ptr_ext);
    end
  end

  // file register write-back strobe, one cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fwr_r <= '0;
    end else begin
      fwr_r.en <= wr_reg;
      fwr_r.addr <= req_i.faddr;
      fwr_r.data <= res;
    end
  end

  // outputs straight from flops
  assign acc_o = acc_r;
  assign flags_o = flags_r;
  assign pointer_pair0_o = ptr_r[0];
  assign pointer_pair1_o = ptr_r[1];
  assign fwr_o = fwr_r;

  // checks
  property p_ptr_flags;
    @(posedge ref_clk_i) disable iff (reset_i)
    is_ptr |=> flags_r == $past(flags_r);
  endproperty
  a_ptr_flags: assert property (p_ptr_flags)
    else $error("pointer add changed flags");

  property p_ptr_wrap;
    @(posedge ref_clk_i) disable iff (reset_i)
    (is_ptr && !req_i.ptr_sel) |=>
      ptr_r[0] == 16'($past(ptr_r[0]) + $past(ptr_ext));
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap)
    else $error("pointer pair sum wrong");

  property p_and_imm;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_AND_IMM) |=>
      acc_r == ($past(acc_r) & $past(req_i.imm)) &&
      flags_r.carry == $past(flags_r.carry);
  endproperty
  a_and_imm: assert property (p_and_imm)
    else $error("immediate and wrong");

  property p_add_imm;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_ADD_IMM) |=>
      {flags_r.carry, acc_r} == {1'b0, $past(acc_r)} + $past(req_i.imm);
  endproperty
  a_add_imm: assert property (p_add_imm)
    else $error("immediate add wrong");

  property p_dest_reg;
    @(posedge ref_clk_i) disable iff (reset_i)
    (wr_reg && req_i.op != mas_pkg::MAS_OP_BCLR_REG) |=>
      fwr_r.en && acc_r == $past(acc_r);
  endproperty
  a_dest_reg: assert property (p_dest_reg)
    else $error("register destination touched accumulator");

  property p_and_reg_z;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_AND_REG) |=>
      flags_r.zero == (($past(acc_r) & $past(freg_rdata_i)) == 8'h00);
  endproperty
  a_and_reg_z: assert property (p_and_reg_z)
    else $error("register and zero flag wrong");

  property p_adc;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_ADC_REG &&
     req_i.dest == mas_pkg::DEST_ACC) |=>
      {flags_r.carry, acc_r} == {1'b0, $past(acc_r)} +
        {1'b0, $past(freg_rdata_i)} + {8'h00, $past(flags_r.carry)};
  endproperty
  a_adc: assert property (p_adc)
    else $error("add with carry wrong");

  property p_asr;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_ASR_REG) |=>
      flags_r.carry == $past(freg_rdata_i[0]);
  endproperty
  a_asr: assert property (p_asr)
    else $error("shift carry wrong");

  property p_bclr;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_BCLR_REG) |=>
      fwr_r.en && !fwr_r.data[$past(req_i.bidx)] &&
      flags_r == $past(flags_r);
  endproperty
  a_bclr: assert property (p_bclr)
    else $error("bit clear wrong");

  // register add into the accumulator, carry out of bit 7 kept
  property p_add_reg;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_ADD_REG &&
     req_i.dest == mas_pkg::DEST_ACC) |=>
      {flags_r.carry, acc_r} ==
        {1'b0, $past(acc_r)} + {1'b0, $past(freg_rdata_i)};
  endproperty
  a_add_reg: assert property (p_add_reg)
    else $error("register add wrong");

  // accumulator destination strobes no register write, except for bit clear
  property p_dest_acc;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op != mas_pkg::MAS_OP_BCLR_REG &&
     req_i.dest == mas_pkg::DEST_ACC) |=> !fwr_r.en;
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("accumulator destination wrote register");

  // and operations leave carry and digit carry alone
  property p_and_keep;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && (req_i.op == mas_pkg::MAS_OP_AND_REG ||
     req_i.op == mas_pkg::MAS_OP_AND_IMM)) |=>
      flags_r.carry == $past(flags_r.carry) &&
      flags_r.low_nibble_flag == $past(flags_r.low_nibble_flag);
  endproperty
  a_and_keep: assert property (p_and_keep)
    else $error("and changed carry flags");

  // digit carry from a plain low nibble sum
  property p_dc_imm;
    @(posedge ref_clk_i) disable iff (reset_i)
    (req_valid_i && req_i.op == mas_pkg::MAS_OP_ADD_IMM) |=>
      flags_r.low_nibble_flag ==
        ((5'h00 + $past(acc_r[3:0]) + $past(req_i.imm[3:0])) > 5'h0f);
  endproperty
  a_dc_imm: assert property (p_dc_imm)
    else $error("digit carry wrong");

  // zero flag agrees with a freshly written accumulator
  property p_zero_acc;
    @(posedge ref_clk_i) disable iff (reset_i)
    (upd_z && wr_acc) |=> flags_r.zero == (acc_r == 8'h00);
  endproperty
  a_zero_acc: assert property (p_zero_acc)
    else $error("zero flag disagrees with accumulator");

  // second pointer pair wraps, first one untouched
  property p_ptr1_wrap;
    @(posedge ref_clk_i) disable iff (reset_i)
    (is_ptr && req_i.ptr_sel) |=>
      ptr_r[1] == 16'($past(ptr_r[1]) + $past(ptr_ext)) &&
      ptr_r[0] == $past(ptr_r[0]);
  endproperty
  a_ptr1_wrap: assert property (p_ptr1_wrap)
    else $error("second pointer pair sum wrong");

  c_ptr: cover property (@(posedge ref_clk_i) is_ptr);
  c_adc: cover property (@(posedge ref_clk_i)
    req_valid_i && req_i.op == mas_pkg::MAS_OP_ADC_REG && flags_r.carry);
  c_asr: cover property (@(posedge ref_clk_i)
    req_valid_i && req_i.op == mas_pkg::MAS_OP_ASR_REG);
  c_add_to_reg: cover property (@(posedge ref_clk_i)
    req_valid_i && req_i.op == mas_pkg::MAS_OP_ADD_REG && wr_reg);
endmodule

// File: tb/tb_mas_alu.sv
module tb_mas_alu;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and request drive
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  mas_pkg::mas_req_t req_i = '0;
  logic [7:0] freg_rdata_i = 8'h00;
  // observed state
  logic [7:0] acc_o;
  mas_pkg::mas_flags_t flags_o;
  logic [15:0] pointer_pair0_o;
  logic [15:0] pointer_pair1_o;
  mas_pkg::mas_fwr_t fwr_o;
  // scoreboard counters
  int n_mismatch = 0;
  int n_checks = 0;

  mas_alu DUT (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .req_valid_i(req_valid_i),
    .req_i(req_i),
    .freg_rdata_i(freg_rdata_i),
    .acc_o(acc_o),
    .flags_o(flags_o),
    .pointer_pair0_o(pointer_pair0_o),
    .pointer_pair1_o(pointer_pair1_o),
    .fwr_o(fwr_o)
  );

  // 4 ns clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // compare one value, four-state exact
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // accumulator and flags {carry, nibble, zero} together
  task chk_af(input logic [7:0] a, input logic [2:0] f);
    chk({8'h00, acc_o}, {8'h00, a});
    chk({13'h0, flags_o}, {13'h0, f});
  endtask

  // file write strobe, address and data
  task chk_fw(input logic e, input logic [6:0] ad, input logic [7:0] d);
    chk({15'h0, fwr_o.en}, {15'h0, e});
    if (e) chk({1'b0, fwr_o.addr, fwr_o.data}, {1'b0, ad, d});
  endtask

  // present one request at a falling edge, result visible one cycle later
  task op(input mas_pkg::mas_op_t o, input logic d, input logic [7:0] k,
          input logic [6:0] fa, input logic [2:0] b, input logic [7:0] rd);
    req_i.op = o;
    req_i.dest = d;
    req_i.imm = k;
    req_i.faddr = fa;
    req_i.bidx = b;
    freg_rdata_i = rd;
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
  endtask

  // pointer add request with signed 6-bit step
  task ptr(input logic s, input logic [5:0] k);
    req_i.ptr_sel = s;
    req_i.pimm = k;
    op(mas_pkg::MAS_OP_PTR_ADD, 1'b0, 8'h00, 7'h00, 3'h0, 8'h00);
  endtask

  // immediate add and and, carries and zero
  task s_imm;
    op(mas_pkg::MAS_OP_ADD_IMM, 1'b0, 8'hff, 7'h00, 3'h0, 8'h00);
    chk_af(8'hff, 3'b000);
    op(mas_pkg::MAS_OP_ADD_IMM, 1'b0, 8'h01, 7'h00, 3'h0, 8'h00);
    chk_af(8'h00, 3'b111);
    op(mas_pkg::MAS_OP_AND_IMM, 1'b0, 8'h5a, 7'h00, 3'h0, 8'h00);
    chk_af(8'h00, 3'b111);
    op(mas_pkg::MAS_OP_ADD_IMM, 1'b0, 8'h88, 7'h00, 3'h0, 8'h00);
    chk_af(8'h88, 3'b000);
    op(mas_pkg::MAS_OP_ADD_IMM, 1'b0, 8'h88, 7'h00, 3'h0, 8'h00);
    chk_af(8'h10, 3'b110);
    op(mas_pkg::MAS_OP_AND_IMM, 1'b0, 8'hf0, 7'h00, 3'h0, 8'h00);
    chk_af(8'h10, 3'b110);
  endtask

  // pointer steps at both ends of the range, flags held
  task s_ptr;
    ptr(1'b0, 6'h20);
    chk(pointer_pair0_o, 16'hffe0);
    ptr(1'b1, 6'h1f);
    chk(pointer_pair1_o, 16'h001f);
    chk(pointer_pair0_o, 16'hffe0);
    ptr(1'b0, 6'h1f);
    chk(pointer_pair0_o, 16'hffff);
    ptr(1'b0, 6'h01);
    chk(pointer_pair0_o, 16'h0000);
    chk_af(8'h10, 3'b110);
  endtask

  // register ops with both destinations, carry in
  task s_reg;
    op(mas_pkg::MAS_OP_AND_REG, 1'b1, 8'h00, 7'h7f, 3'h0, 8'h35);
    chk_fw(1'b1, 7'h7f, 8'h10);
    chk_af(8'h10, 3'b110);
    op(mas_pkg::MAS_OP_ADD_REG, 1'b0, 8'h00, 7'h00, 3'h0, 8'hf9);
    chk_fw(1'b0, 7'h00, 8'h00);
    chk_af(8'h09, 3'b100);
    op(mas_pkg::MAS_OP_ADC_REG, 1'b1, 8'h00, 7'h55, 3'h0, 8'hf6);
    chk_fw(1'b1, 7'h55, 8'h00);
    chk_af(8'h09, 3'b111);
    op(mas_pkg::MAS_OP_ADC_REG, 1'b0, 8'h00, 7'h55, 3'h0, 8'h00);
    chk_af(8'h0a, 3'b000);
    op(mas_pkg::MAS_OP_AND_REG, 1'b0, 8'h00, 7'h2a, 3'h0, 8'h05);
    chk_fw(1'b0, 7'h00, 8'h00);
    chk_af(8'h00, 3'b001);
    op(mas_pkg::MAS_OP_ADD_REG, 1'b1, 8'h00, 7'h2a, 3'h0, 8'h10);
    chk_fw(1'b1, 7'h2a, 8'h10);
    chk_af(8'h00, 3'b000);
  endtask

  // shift right keeps msb, bit clear walks every index
  task s_bits;
    int i;
    op(mas_pkg::MAS_OP_ASR_REG, 1'b0, 8'h00, 7'h12, 3'h0, 8'h81);
    chk_af(8'hc0, 3'b100);
    op(mas_pkg::MAS_OP_ASR_REG, 1'b1, 8'h00, 7'h12, 3'h0, 8'h01);
    chk_fw(1'b1, 7'h12, 8'h00);
    chk_af(8'hc0, 3'b101);
    for (i = 0; i < 8; i++) begin
      op(mas_pkg::MAS_OP_BCLR_REG, 1'b1, 8'h00, 7'h40, i[2:0], 8'hff);
      chk_fw(1'b1, 7'h40, ~(8'h01 << i));
      chk_af(8'hc0, 3'b101);
    end
    op(mas_pkg::MAS_OP_NONE, 1'b1, 8'h00, 7'h40, 3'h0, 8'hff);
    chk_fw(1'b0, 7'h00, 8'h00);
    chk_af(8'hc0, 3'b101);
  endtask

  // verdict and end of run
  task print_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(negedge ref_clk_i);
    chk_af(8'h00, 3'b000);
    chk({pointer_pair0_o | pointer_pair1_o}, 16'h0000);
    chk_fw(1'b0, 7'h00, 8'h00);
    reset_i = 1'b0;
    s_imm();
    s_ptr();
    s_reg();
    s_bits();
    req_valid_i = 1'b0;
    @(negedge ref_clk_i);
    print_verdict();
  end

  // hang guard, far beyond the few dozen cycles needed
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule
